// ### common/hcmd_map.vh
// constants for the operand address generator
`ifndef HCMD_MAP_VH
`define HCMD_MAP_VH

// ****************************************
// prefix bytes
// ****************************************
`define HCMD_PFX_Y 8'h90
`define HCMD_PFX_IY 8'h91
`define HCMD_PFX_I 8'h92
// latched prefix kind
`define HCMD_PK_NONE 2'h0
`define HCMD_PK_Y 2'h1
`define HCMD_PK_I 2'h2
`define HCMD_PK_IY 2'h3

// ****************************************
// addressing mode codes
// ****************************************
`define HCMD_M_INH 5'h00
`define HCMD_M_IMM 5'h01
`define HCMD_M_DIR_S 5'h02
`define HCMD_M_DIR_L 5'h03
`define HCMD_M_IDX_0 5'h04
`define HCMD_M_IDX_S 5'h05
`define HCMD_M_IDX_L 5'h06
`define HCMD_M_IND_S 5'h07
`define HCMD_M_IND_L 5'h08
`define HCMD_M_IIX_S 5'h09
`define HCMD_M_IIX_L 5'h0A
`define HCMD_M_REL_D 5'h0B
`define HCMD_M_REL_I 5'h0C
`define HCMD_M_BIT_D 5'h0D
`define HCMD_M_BIT_I 5'h0E
`define HCMD_M_BTR_D 5'h0F
`define HCMD_M_BTR_I 5'h10

// ****************************************
// opcode layout: column in [7:4], class in [3:2]
// ****************************************
`define HCMD_COL_HI 7
`define HCMD_COL_LO 4
`define HCMD_CLS_HI 3
`define HCMD_CLS_LO 2
`define HCMD_C_INH 4'h0
`define HCMD_C_IMM 4'h1
`define HCMD_C_DIR_S 4'h2
`define HCMD_C_DIR_L 4'h3
`define HCMD_C_IDX_0 4'h4
`define HCMD_C_IDX_S 4'h5
`define HCMD_C_IDX_L 4'h6
`define HCMD_C_REL 4'h7
`define HCMD_C_BIT 4'h8
`define HCMD_C_BTR 4'h9
`define HCMD_K_ALU 2'h0
`define HCMD_K_RMW 2'h1
`define HCMD_K_JMP 2'h2

`endif

// ### rtl/hcmd_add.v
// unsigned or sign-extended offset adder
`timescale 1ns/1ps
module hcmd_add #(
    parameter AW = 16,
    parameter OW = 8
) (
    a,
    off,
    sgn,
    sum
);
    input wire [AW-1:0] a;
    input wire [OW-1:0] off;
    input wire sgn;
    output wire [AW-1:0] sum;

    wire ext;
    assign ext = sgn & off[OW-1];
    // zero extension gives the unsigned index sum, sign extension the branch
    assign sum = a + {{(AW-OW){ext}}, off};
endmodule

// ### rtl/hcmd_mode_dec.v
// prefix and opcode to addressing mode decoder
`timescale 1ns/1ps
`include "hcmd_map.vh"
module hcmd_mode_dec (
    pfx,
    opc,
    mode,
    nopnd,
    nmem,
    illegal
);
    input wire [1:0] pfx;
    input wire [7:0] opc;
    output reg [4:0] mode;
    output reg [1:0] nopnd;
    output reg [1:0] nmem;
    output reg illegal;

    wire [3:0] col;
    wire [1:0] cls;
    wire pi;
    wire py;
    wire pn;
    wire short_only;
    assign col = opc[`HCMD_COL_HI:`HCMD_COL_LO];
    assign cls = opc[`HCMD_CLS_HI:`HCMD_CLS_LO];
    assign pi = (pfx == `HCMD_PK_I);
    assign py = (pfx == `HCMD_PK_Y);
    assign pn = (pfx == `HCMD_PK_NONE);
    assign short_only = (cls == `HCMD_K_RMW) || (cls == `HCMD_K_JMP);

    always @* begin
        mode = `HCMD_M_INH;
        nopnd = 2'h0;
        nmem = 2'h0;
        illegal = 1'b0;
        case (col)
            `HCMD_C_INH: begin
                illegal = !(pn || py);
            end
            `HCMD_C_IMM: begin
                mode = `HCMD_M_IMM;
                nopnd = 2'h1;
                illegal = !(pn || py);
            end
            `HCMD_C_DIR_S: begin
                mode = pi ? `HCMD_M_IND_S : `HCMD_M_DIR_S;
                nopnd = 2'h1;
                nmem = pi ? 2'h1 : 2'h0;
                illegal = (pfx == `HCMD_PK_IY);
            end
            `HCMD_C_DIR_L: begin
                mode = pi ? `HCMD_M_IND_L : `HCMD_M_DIR_L;
                nopnd = pi ? 2'h1 : 2'h2;
                nmem = pi ? 2'h2 : 2'h0;
                illegal = (pfx == `HCMD_PK_IY) || short_only;
            end
            `HCMD_C_IDX_0: begin
                mode = `HCMD_M_IDX_0;
                illegal = !(pn || py);
            end
            `HCMD_C_IDX_S: begin
                mode = (pn || py) ? `HCMD_M_IDX_S : `HCMD_M_IIX_S;
                nopnd = 2'h1;
                nmem = (pn || py) ? 2'h0 : 2'h1;
            end
            `HCMD_C_IDX_L: begin
                mode = (pn || py) ? `HCMD_M_IDX_L : `HCMD_M_IIX_L;
                nopnd = (pn || py) ? 2'h2 : 2'h1;
                nmem = (pn || py) ? 2'h0 : 2'h2;
                illegal = short_only;
            end
            `HCMD_C_REL: begin
                mode = pi ? `HCMD_M_REL_I : `HCMD_M_REL_D;
                nopnd = 2'h1;
                nmem = pi ? 2'h1 : 2'h0;
                illegal = !(pn || pi);
            end
            `HCMD_C_BIT: begin
                mode = pi ? `HCMD_M_BIT_I : `HCMD_M_BIT_D;
                nopnd = 2'h1;
                nmem = pi ? 2'h1 : 2'h0;
                illegal = !(pn || pi);
            end
            `HCMD_C_BTR: begin
                mode = pi ? `HCMD_M_BTR_I : `HCMD_M_BTR_D;
                nopnd = 2'h2;
                nmem = pi ? 2'h1 : 2'h0;
                illegal = !(pn || pi);
            end
            default: begin
                illegal = 1'b1;
            end
        endcase
        if (illegal) begin
            nopnd = 2'h0;
            nmem = 2'h0;
        end
    end
endmodule

// ### rtl/hcmd_addr_gen.v
// operand address generator: byte collection, pointer reads, address forming
`timescale 1ns/1ps
`include "hcmd_map.vh"
module hcmd_addr_gen (
    sys_clk,
    rst_n,
    fb_valid,
    fb_byte,
    fb_pc,
    fb_ready,
    x_idx,
    y_idx,
    mem_req,
    mem_addr,
    mem_rdata,
    mem_rvalid,
    dec_busy,
    dec_done,
    dec_illegal,
    dec_mode,
    dec_len,
    dec_opcode,
    dec_use_y,
    dec_imm,
    dec_ea,
    dec_target
);
    input wire sys_clk;
    input wire rst_n;
    input wire fb_valid;
    input wire [7:0] fb_byte;
    input wire [15:0] fb_pc;
    output wire fb_ready;
    input wire [7:0] x_idx;
    input wire [7:0] y_idx;
    output wire mem_req;
    output wire [15:0] mem_addr;
    input wire [7:0] mem_rdata;
    input wire mem_rvalid;
    output wire dec_busy;
    output wire dec_done;
    output wire dec_illegal;
    output wire [4:0] dec_mode;
    output wire [2:0] dec_len;
    output wire [7:0] dec_opcode;
    output wire dec_use_y;
    output wire [7:0] dec_imm;
    output wire [15:0] dec_ea;
    output wire [15:0] dec_target;

    // ****************************************
    // states
    // ****************************************
    localparam S_IDLE = 3'h0;
    localparam S_OPC = 3'h1;
    localparam S_OPND = 3'h2;
    localparam S_MEM = 3'h3;
    localparam S_CALC = 3'h4;

    reg [2:0] state_r;
    reg [2:0] state_nxt;
    reg [1:0] pfx_r;
    reg dbl_r;
    reg [7:0] opc_r;
    reg [15:0] pc_r;
    reg [7:0] b0_r;
    reg [7:0] b1_r;
    reg [1:0] cnt_r;
    reg [7:0] p0_r;
    reg [7:0] p1_r;
    reg [1:0] mcnt_r;
    reg [15:0] maddr_r;
    reg done_r;
    reg ill_r;
    reg [4:0] mode_r;
    reg [2:0] len_r;
    reg [7:0] opo_r;
    reg usey_r;
    reg [7:0] imm_r;
    reg [15:0] ea_r;
    reg [15:0] tgt_r;

    // ****************************************
    // mode decoding
    // ****************************************
    wire [4:0] mode;
    wire [1:0] nopnd;
    wire [1:0] nmem;
    wire illegal;

    hcmd_mode_dec u_dec (
        .pfx(pfx_r),
        .opc(opc_r),
        .mode(mode),
        .nopnd(nopnd),
        .nmem(nmem),
        .illegal(illegal)
    );

    wire bad;
    assign bad = illegal | dbl_r;

    // prefix kind of an incoming byte
    reg [1:0] pk;
    always @* begin
        case (fb_byte)
            `HCMD_PFX_Y: pk = `HCMD_PK_Y;
            `HCMD_PFX_I: pk = `HCMD_PK_I;
            `HCMD_PFX_IY: pk = `HCMD_PK_IY;
            default: pk = `HCMD_PK_NONE;
        endcase
    end

    wire is_pfx;
    assign is_pfx = (pk != `HCMD_PK_NONE);

    // ****************************************
    // handshakes
    // ****************************************
    wire opnd_need;
    // a second prefix makes the instruction illegal, so no operand byte is taken
    assign opnd_need = (state_r == S_OPND) && !dbl_r && (cnt_r != nopnd);
    assign fb_ready = (state_r == S_IDLE) || (state_r == S_OPC) || opnd_need;
    wire take;
    assign take = fb_valid & fb_ready;
    assign mem_req = (state_r == S_MEM);
    assign mem_addr = maddr_r;
    assign dec_busy = (state_r != S_IDLE);

    // ****************************************
    // state sequencing
    // ****************************************
    always @* begin
        state_nxt = state_r;
        case (state_r)
            S_IDLE: begin
                if (take) begin
                    state_nxt = is_pfx ? S_OPC : S_OPND;
                end
            end
            S_OPC: begin
                if (take) begin
                    state_nxt = S_OPND;
                end
            end
            S_OPND: begin
                if (!opnd_need) begin
                    state_nxt = (nmem != 2'h0 && !bad) ? S_MEM : S_CALC;
                end
            end
            S_MEM: begin
                if (mem_rvalid && (mcnt_r + 2'h1 == nmem)) begin
                    state_nxt = S_CALC;
                end
            end
            S_CALC: begin
                state_nxt = S_IDLE;
            end
            default: begin
                state_nxt = S_IDLE;
            end
        endcase
    end

    // ****************************************
    // byte collection and pointer reads
    // ****************************************
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            state_r <= S_IDLE;
            pfx_r <= `HCMD_PK_NONE;
            dbl_r <= 1'b0;
            opc_r <= 8'h00;
            pc_r <= 16'h0000;
            b0_r <= 8'h00;
            b1_r <= 8'h00;
            cnt_r <= 2'h0;
            p0_r <= 8'h00;
            p1_r <= 8'h00;
            mcnt_r <= 2'h0;
            maddr_r <= 16'h0000;
        end else begin
            state_r <= state_nxt;
            if (state_r == S_IDLE && take) begin
                pc_r <= fb_pc;
                cnt_r <= 2'h0;
                dbl_r <= 1'b0;
                pfx_r <= pk;
                opc_r <= fb_byte;
            end
            if (state_r == S_OPC && take) begin
                dbl_r <= is_pfx;
                opc_r <= fb_byte;
            end
            if (opnd_need && fb_valid) begin
                if (cnt_r == 2'h0) begin
                    b0_r <= fb_byte;
                end else begin
                    b1_r <= fb_byte;
                end
                cnt_r <= cnt_r + 2'h1;
            end
            if (state_r == S_OPND && state_nxt == S_MEM) begin
                // pointer address sits in page zero
                maddr_r <= {8'h00, b0_r};
                mcnt_r <= 2'h0;
            end
            if (state_r == S_MEM && mem_rvalid) begin
                if (mcnt_r == 2'h0) begin
                    p0_r <= mem_rdata;
                end else begin
                    p1_r <= mem_rdata;
                end
                mcnt_r <= mcnt_r + 2'h1;
                // the low byte of a word pointer wraps inside page zero
                maddr_r <= {8'h00, maddr_r[7:0] + 8'h01};
            end
        end
    end

    // ****************************************
    // address forming
    // ****************************************
    wire [15:0] ptr;
    assign ptr = (nmem == 2'h2) ? {p0_r, p1_r} : {8'h00, p0_r};

    wire use_y;
    assign use_y = (pfx_r == `HCMD_PK_Y) || (pfx_r == `HCMD_PK_IY);

    reg [15:0] base;
    reg [7:0] idx;
    reg [7:0] roff;
    always @* begin
        base = 16'h0000;
        idx = 8'h00;
        roff = 8'h00;
        case (mode)
            `HCMD_M_DIR_S, `HCMD_M_BIT_D: base = {8'h00, b0_r};
            `HCMD_M_DIR_L: base = {b0_r, b1_r};
            `HCMD_M_IDX_0: idx = use_y ? y_idx : x_idx;
            `HCMD_M_IDX_S: begin
                base = {8'h00, b0_r};
                idx = use_y ? y_idx : x_idx;
            end
            `HCMD_M_IDX_L: begin
                base = {b0_r, b1_r};
                idx = use_y ? y_idx : x_idx;
            end
            `HCMD_M_IND_S, `HCMD_M_IND_L, `HCMD_M_BIT_I: base = ptr;
            `HCMD_M_IIX_S, `HCMD_M_IIX_L: begin
                base = ptr;
                idx = use_y ? y_idx : x_idx;
            end
            `HCMD_M_REL_D: roff = b0_r;
            `HCMD_M_REL_I: roff = p0_r;
            `HCMD_M_BTR_D: begin
                base = {8'h00, b0_r};
                roff = b1_r;
            end
            `HCMD_M_BTR_I: begin
                base = ptr;
                roff = b1_r;
            end
            default: base = 16'h0000;
        endcase
    end

    wire [15:0] ea_sum;
    hcmd_add #(
        .AW(16),
        .OW(8)
    ) u_ea_add (
        .a(base),
        .off(idx),
        .sgn(1'b0),
        .sum(ea_sum)
    );

    wire [2:0] len;
    assign len = {2'h0, pfx_r != `HCMD_PK_NONE} + 3'h1 + {1'b0, nopnd};

    wire [15:0] pc_next;
    assign pc_next = pc_r + {13'h0000, len};

    wire [15:0] tgt_sum;
    hcmd_add #(
        .AW(16),
        .OW(8)
    ) u_rel_add (
        .a(pc_next),
        .off(roff),
        .sgn(1'b1),
        .sum(tgt_sum)
    );

    wire rel_mode;
    assign rel_mode = (mode == `HCMD_M_REL_D) || (mode == `HCMD_M_REL_I) ||
        (mode == `HCMD_M_BTR_D) || (mode == `HCMD_M_BTR_I);

    // ****************************************
    // result registers
    // ****************************************
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            done_r <= 1'b0;
            ill_r <= 1'b0;
            mode_r <= `HCMD_M_INH;
            len_r <= 3'h0;
            opo_r <= 8'h00;
            usey_r <= 1'b0;
            imm_r <= 8'h00;
            ea_r <= 16'h0000;
            tgt_r <= 16'h0000;
        end else begin
            done_r <= (state_r == S_CALC);
            if (state_r == S_CALC) begin
                ill_r <= bad;
                mode_r <= mode;
                len_r <= len;
                opo_r <= opc_r;
                usey_r <= use_y;
                imm_r <= (mode == `HCMD_M_IMM && !bad) ? b0_r : 8'h00;
                ea_r <= (bad || rel_mode && mode != `HCMD_M_BTR_D &&
                    mode != `HCMD_M_BTR_I) ? 16'h0000 : ea_sum;
                tgt_r <= (rel_mode && !bad) ? tgt_sum : pc_next;
            end
        end
    end

    assign dec_done = done_r;
    assign dec_illegal = ill_r;
    assign dec_mode = mode_r;
    assign dec_len = len_r;
    assign dec_opcode = opo_r;
    assign dec_use_y = usey_r;
    assign dec_imm = imm_r;
    assign dec_ea = ea_r;
    assign dec_target = tgt_r;
endmodule

// ### verif/hcmd_addr_gen_sva.sv
// concurrent checks on the operand address generator ports
`timescale 1ns/1ps
`include "hcmd_map.vh"
module hcmd_addr_gen_sva (
    input wire sys_clk,
    input wire rst_n,
    input wire fb_ready,
    input wire mem_req,
    input wire [15:0] mem_addr,
    input wire dec_busy,
    input wire dec_done,
    input wire dec_illegal,
    input wire [4:0] dec_mode,
    input wire [2:0] dec_len,
    input wire [7:0] dec_opcode,
    input wire dec_use_y,
    input wire [15:0] dec_ea
);
    wire fin;
    wire [2:0] plen;
    // the index prefix adds one byte in front of the opcode
    assign fin = dec_done && !dec_illegal;
    assign plen = {2'h0, dec_use_y};
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    a_done_pulse: assert property (dec_done |=> !dec_done)
        else $error("done held longer than one cycle");
    a_ptr_page: assert property (mem_req |-> mem_addr[15:8] == 8'h00)
        else $error("pointer read outside page zero");
    a_fetch_refused: assert property (mem_req |-> !fb_ready)
        else $error("fetch byte accepted during pointer read");
    a_inh_len: assert property (fin && dec_mode == `HCMD_M_INH |-> dec_len == 3'h1 + plen)
        else $error("inherent length wrong");
    a_dir_short: assert property (fin && dec_mode == `HCMD_M_DIR_S
        |-> dec_ea[15:8] == 8'h00 && dec_len == 3'h2 + plen)
        else $error("short direct out of page or wrong length");
    a_dir_long: assert property (fin && dec_mode == `HCMD_M_DIR_L |-> dec_len == 3'h3 + plen)
        else $error("long direct length wrong");
    a_idx_none: assert property (fin && dec_mode == `HCMD_M_IDX_0
        |-> dec_ea[15:8] == 8'h00 && dec_len == 3'h1 + plen)
        else $error("indexed without offset wrong");
    a_idx_reach: assert property (fin && dec_mode == `HCMD_M_IDX_S
        |-> dec_ea <= 16'h01FE && dec_len == 3'h2 + plen)
        else $error("short indexed reach or length wrong");
    a_ind_len: assert property (fin && dec_mode >= `HCMD_M_IND_S
        && dec_mode <= `HCMD_M_IIX_L |-> dec_len == 3'h3)
        else $error("indirect length wrong");
    a_bit_page: assert property (fin && dec_mode >= `HCMD_M_BIT_D |-> dec_ea[15:8] == 8'h00)
        else $error("bit operand outside page zero");
    a_short_only: assert property (fin && (dec_opcode[3:2] == `HCMD_K_RMW
        || dec_opcode[3:2] == `HCMD_K_JMP) |-> dec_mode != `HCMD_M_DIR_L
        && dec_mode != `HCMD_M_IDX_L && dec_mode != `HCMD_M_IND_L && dec_mode != `HCMD_M_IIX_L)
        else $error("long form accepted for short-only class");
    a_read_bound: assert property ($rose(mem_req) |-> ##[1:40] !mem_req)
        else $error("pointer read never finished");
    a_done_idle: assert property (dec_done |-> fb_ready && !mem_req && !dec_busy)
        else $error("not idle when done");
endmodule

bind hcmd_addr_gen hcmd_addr_gen_sva chk (
    .sys_clk(sys_clk), .rst_n(rst_n), .fb_ready(fb_ready), .mem_req(mem_req),
    .mem_addr(mem_addr), .dec_busy(dec_busy), .dec_done(dec_done),
    .dec_illegal(dec_illegal), .dec_mode(dec_mode), .dec_len(dec_len),
    .dec_opcode(dec_opcode), .dec_use_y(dec_use_y), .dec_ea(dec_ea)
);

// ### verif/hcmd_mem_model.sv
// page-zero memory answering pointer reads, promptly or after a set wait
`timescale 1ns/1ps
module hcmd_mem_model (
    input wire sys_clk,
    input wire rst_n,
    input wire mem_req,
    input wire [15:0] mem_addr,
    input wire [3:0] lat,
    output wire [7:0] mem_rdata,
    output wire mem_rvalid
);
    logic [7:0] mem_r [0:255];
    logic [7:0] last_r;
    logic [3:0] wait_r;
    // outside an answer the data lines never show the last byte again
    assign mem_rvalid = mem_req && (wait_r == lat);
    assign mem_rdata = mem_rvalid ? mem_r[mem_addr[7:0]] : ~last_r;
    always @(posedge sys_clk) begin
        if (!rst_n || !mem_req || mem_rvalid) begin
            wait_r <= 4'h0;
        end else begin
            wait_r <= wait_r + 4'h1;
        end
        if (!rst_n) begin
            last_r <= 8'h00;
        end else if (mem_rvalid) begin
            last_r <= mem_rdata;
        end
    end
endmodule

// ### verif/test_cpu_operand_address_modes.sv
// self-checking bench for the operand address generator
`timescale 1ns/1ps
`define CHK(g, e, m) begin check_count++; if ((g) !== (e)) begin n_errors++; $display("MISMATCH %0t %s", $time, m); end end
module test_cpu_operand_address_modes;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic fb_valid = 1'b0;
    logic [7:0] fb_byte = 8'h00;
    logic [15:0] fb_pc = 16'h0000;
    logic [7:0] x_idx = 8'h00;
    logic [7:0] y_idx = 8'h00;
    logic [3:0] lat = 4'h0;
    logic [15:0] pc_g = 16'h0F00;
    wire fb_ready, mem_req, mem_rvalid, dec_busy, dec_done, dec_illegal, dec_use_y;
    wire [15:0] mem_addr, dec_ea, dec_target;
    wire [7:0] mem_rdata, dec_opcode, dec_imm;
    wire [4:0] dec_mode;
    wire [2:0] dec_len;
    int n_errors = 0;
    int check_count = 0;
    int n_rd = 0;
    int cyc = 0;

    hcmd_addr_gen dut (.sys_clk(sys_clk), .rst_n(rst_n), .fb_valid(fb_valid),
        .fb_byte(fb_byte), .fb_pc(fb_pc), .fb_ready(fb_ready), .x_idx(x_idx), .y_idx(y_idx),
        .mem_req(mem_req), .mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid),
        .dec_busy(dec_busy), .dec_done(dec_done), .dec_illegal(dec_illegal),
        .dec_mode(dec_mode), .dec_len(dec_len), .dec_opcode(dec_opcode),
        .dec_use_y(dec_use_y), .dec_imm(dec_imm), .dec_ea(dec_ea), .dec_target(dec_target));
    hcmd_mem_model pm (.sys_clk(sys_clk), .rst_n(rst_n), .mem_req(mem_req),
        .mem_addr(mem_addr), .lat(lat), .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid));

    always #5 sys_clk = ~sys_clk;

    // ****************************************
    // cycle ceiling and read counter
    // ****************************************
    always @(posedge sys_clk) begin
        cyc++;
        if (mem_rvalid === 1'b1) n_rd++;
        if (cyc == 3000) begin
            n_errors++;
            summarize();
        end
    end

    task automatic summarize;
        if (n_errors == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // ****************************************
    // byte offer and instruction run
    // ****************************************
    task automatic send(input logic [7:0] b);
        int k;
        begin
            fb_valid = 1'b1;
            fb_byte = b;
            fb_pc = pc_g;
            k = 0;
            while (fb_ready !== 1'b1 && k < 40) begin @(negedge sys_clk); k++; end
            @(negedge sys_clk);
        end
    endtask

    // po: prefix (00 for none) and opcode; fl: index select, illegal
    task automatic run(input logic [15:0] po, input int nb, input logic [15:0] ob,
        input logic [4:0] md, input logic [2:0] ln, input logic [15:0] ea,
        input logic [7:0] off, input logic [1:0] fl, input int nr);
        int k;
        begin
            n_rd = 0;
            if (po[15:8] != 8'h00) send(po[15:8]);
            send(po[7:0]);
            if (nb > 0) send(ob[15:8]);
            if (nb > 1) send(ob[7:0]);
            fb_valid = 1'b0;
            `CHK(dec_busy, 1'b1, "not busy while decoding")
            k = 0;
            while (dec_done !== 1'b1 && k < 40) begin @(negedge sys_clk); k++; end
            `CHK(dec_illegal, fl[0], "illegal flag")
            if (fl[0] || md > 5'h01) `CHK(dec_ea, ea, "effective address")
            `CHK(n_rd, nr, "pointer read count")
            `CHK(fb_ready, 1'b1, "next byte refused")
            if (!fl[0]) begin
                `CHK(dec_mode, md, "mode")
                `CHK(dec_len, ln, "length")
                `CHK(dec_opcode, po[7:0], "opcode")
                `CHK(dec_use_y, fl[1], "index select")
                `CHK(dec_target, pc_g + {13'h0, ln} + {{8{off[7]}}, off}, "target")
            end
            pc_g = pc_g + 16'h0F35;
            @(negedge sys_clk);
        end
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_inh_imm;
        run(16'h0000, 0, 16'h0000, 5'h00, 3'h1, 16'h0000, 8'h00, 2'b00, 0);
        run(16'h0010, 1, 16'h5500, 5'h01, 3'h2, 16'h0000, 8'h00, 2'b00, 0);
        `CHK(dec_imm, 8'h55, "immediate byte")
        run(16'h9000, 0, 16'h0000, 5'h00, 3'h2, 16'h0000, 8'h00, 2'b10, 0);
    endtask

    task automatic t_direct;
        run(16'h0020, 1, 16'hF300, 5'h02, 3'h2, 16'h00F3, 8'h00, 2'b00, 0);
        run(16'h0030, 2, 16'h1234, 5'h03, 3'h3, 16'h1234, 8'h00, 2'b00, 0);
    endtask

    task automatic t_indexed;
        x_idx = 8'hFF;
        run(16'h0040, 0, 16'h0000, 5'h04, 3'h1, 16'h00FF, 8'h00, 2'b00, 0);
        run(16'h0050, 1, 16'hFF00, 5'h05, 3'h2, 16'h01FE, 8'h00, 2'b00, 0);
        x_idx = 8'h20;
        y_idx = 8'h05;
        run(16'h0060, 2, 16'hFFF0, 5'h06, 3'h3, 16'h0010, 8'h00, 2'b00, 0);
        run(16'h9050, 1, 16'h1000, 5'h05, 3'h3, 16'h0015, 8'h00, 2'b10, 0);
        run(16'h9060, 2, 16'h1200, 5'h06, 3'h4, 16'h1205, 8'h00, 2'b10, 0);
    endtask

    task automatic t_indirect(input logic [3:0] l);
        lat = l;
        x_idx = 8'hFF;
        y_idx = 8'h20;
        run(16'h9220, 1, 16'h4000, 5'h07, 3'h3, 16'h00C7, 8'h00, 2'b00, 1);
        run(16'h9230, 1, 16'hFF00, 5'h08, 3'h3, 16'hABCD, 8'h00, 2'b00, 2);
        run(16'h9250, 1, 16'h4100, 5'h09, 3'h3, 16'h01FE, 8'h00, 2'b00, 1);
        run(16'h9260, 1, 16'h5000, 5'h0A, 3'h3, 16'h13EF, 8'h00, 2'b00, 2);
        run(16'h9150, 1, 16'h4100, 5'h09, 3'h3, 16'h011F, 8'h00, 2'b10, 1);
        run(16'h9160, 1, 16'h5000, 5'h0A, 3'h3, 16'h1310, 8'h00, 2'b10, 2);
    endtask

    task automatic t_relative;
        run(16'h0070, 1, 16'h8000, 5'h0B, 3'h2, 16'h0000, 8'h80, 2'b00, 0);
        run(16'h0078, 1, 16'h7F00, 5'h0B, 3'h2, 16'h0000, 8'h7F, 2'b00, 0);
        run(16'h9270, 1, 16'h6000, 5'h0C, 3'h3, 16'h0000, 8'h7F, 2'b00, 1);
    endtask

    task automatic t_bit;
        run(16'h0080, 1, 16'h3300, 5'h0D, 3'h2, 16'h0033, 8'h00, 2'b00, 0);
        run(16'h9280, 1, 16'h3400, 5'h0E, 3'h3, 16'h0099, 8'h00, 2'b00, 1);
        run(16'h0094, 2, 16'h35FE, 5'h0F, 3'h3, 16'h0035, 8'hFE, 2'b00, 0);
        run(16'h9294, 2, 16'h3605, 5'h10, 3'h4, 16'h0077, 8'h05, 2'b00, 1);
    endtask

    task automatic t_classes;
        run(16'h0024, 1, 16'h1000, 5'h02, 3'h2, 16'h0010, 8'h00, 2'b00, 0);
        run(16'h0034, 0, 16'h0000, 5'h00, 3'h0, 16'h0000, 8'h00, 2'b01, 0);
        run(16'h0064, 0, 16'h0000, 5'h00, 3'h0, 16'h0000, 8'h00, 2'b01, 0);
        run(16'h9234, 0, 16'h0000, 5'h00, 3'h0, 16'h0000, 8'h00, 2'b01, 0);
        run(16'h0028, 1, 16'h2000, 5'h02, 3'h2, 16'h0020, 8'h00, 2'b00, 0);
        run(16'h0038, 0, 16'h0000, 5'h00, 3'h0, 16'h0000, 8'h00, 2'b01, 0);
        run(16'h003C, 2, 16'h5678, 5'h03, 3'h3, 16'h5678, 8'h00, 2'b00, 0);
        run(16'h9120, 0, 16'h0000, 5'h00, 3'h0, 16'h0000, 8'h00, 2'b01, 0);
        run(16'h9090, 0, 16'h0000, 5'h00, 3'h0, 16'h0000, 8'h00, 2'b01, 0);
        run(16'h9290, 0, 16'h0000, 5'h00, 3'h0, 16'h0000, 8'h00, 2'b01, 0);
        run(16'h00A0, 0, 16'h0000, 5'h00, 3'h0, 16'h0000, 8'h00, 2'b01, 0);
    endtask

    task automatic t_reset_mid;
        send(8'h30);
        send(8'h12);
        fb_valid = 1'b0;
        rst_n = 1'b0;
        repeat (2) @(negedge sys_clk);
        rst_n = 1'b1;
        @(negedge sys_clk);
        run(16'h0020, 1, 16'h4400, 5'h02, 3'h2, 16'h0044, 8'h00, 2'b00, 0);
    endtask

    initial begin
        pm.mem_r[8'h40] = 8'hC7;
        pm.mem_r[8'hFF] = 8'hAB;
        pm.mem_r[8'h00] = 8'hCD;
        pm.mem_r[8'h41] = 8'hFF;
        pm.mem_r[8'h50] = 8'h12;
        pm.mem_r[8'h51] = 8'hF0;
        pm.mem_r[8'h60] = 8'h7F;
        pm.mem_r[8'h34] = 8'h99;
        pm.mem_r[8'h36] = 8'h77;
        repeat (2) @(negedge sys_clk);
        rst_n = 1'b1;
        @(negedge sys_clk);
        t_inh_imm();
        t_direct();
        t_indexed();
        t_indirect(4'h0);
        t_indirect(4'h3);
        t_relative();
        t_bit();
        t_classes();
        t_reset_mid();
        summarize();
    end
endmodule
